// File: rtl/gfp_panel.sv
`timescale 1ns/1ps
module gfp_panel #(
  parameter int MS_CYC_P = gfp_pkg::MS_CYC,
  parameter int HOLD_MS_P = gfp_pkg::HOLD_MS,
  parameter int NOUT = 8
) (
  // system
  input wire logic clock,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // front panel keys and control pins
  input wire logic [gfp_pkg::NK-1:0] key_in,
  input wire logic remote_start_in,
  input wire logic mains_sim_in,
  input wire logic forced_start_input,
  // supply and fault conditions
  input wire logic mains_volt_ok,
  input wire logic mains_freq_ok,
  input wire logic mains_rot_ok,
  input wire logic gen_volt_ok,
  input wire logic gen_freq_ok,
  input wire logic gen_rot_ok,
  input wire logic shutdown_fault,
  input wire logic loaddump_fault,
  input wire logic warning_fault,
  input wire logic svc_hours_over,
  input wire logic svc_time_over,
  input wire logic [3:0] alarm_count,
  // lamps
  output logic [3:0] mode_lamp,
  output logic alarm_lamp,
  output logic warning_lamp,
  output logic service_lamp,
  output logic mains_avail_lamp,
  output logic mains_cb_lamp,
  output logic gen_cb_lamp,
  output logic gen_avail_lamp,
  // contactors and functions
  output logic mains_contactor,
  output logic gen_contactor,
  output logic [NOUT-1:0] service_out,
  output logic [1:0] service_fault,
  output logic service_reset,
  output logic alarm_relay_release,
  output logic prog_mode,
  output gfp_pkg::gfp_mode_t mode,
  // display position
  output logic [3:0] group,
  output logic [3:0] screen
);
  import gfp_pkg::*;

  if (MS_CYC_P < 2 || HOLD_MS_P < 2 || NOUT < 1 || NOUT > 32) begin : g_chk
    $error("gfp_panel: parameter out of range");
  end

  // ==========================================================
  // apb registers
  logic [CTL_W-1:0] ctrl;
  logic [7:0] scroll_int;
  logic [NOUT-1:0] route;
  logic addr_ok, wr, cmd_wr;
  logic [31:0] stat;
  assign addr_ok = paddr == OFS_CTRL || paddr == OFS_SCROLL || paddr == OFS_ROUTE ||
                   paddr == OFS_CMD || paddr == OFS_STAT;
  assign wr = psel && penable && pwrite && addr_ok;
  assign cmd_wr = wr && paddr == OFS_CMD;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign stat = {8'h00, screen, group, mode, 4'h0, prog_mode, service_lamp, gen_contactor,
                 mains_contactor, mains_avail_lamp, gen_avail_lamp, alarm_lamp, warning_lamp};

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
      scroll_int <= SCROLL_RST;
      route <= '0;
    end else if (wr) begin
      if (paddr == OFS_CTRL) ctrl <= pwdata[CTL_W-1:0];
      if (paddr == OFS_SCROLL) scroll_int <= pwdata[7:0];
      if (paddr == OFS_ROUTE) route <= pwdata[NOUT-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      case (paddr)
        OFS_CTRL: prdata <= 32'(ctrl);
        OFS_SCROLL: prdata <= 32'(scroll_int);
        OFS_ROUTE: prdata <= 32'(route);
        OFS_CMD: prdata <= 32'(mode);
        OFS_STAT: prdata <= stat;
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // pin synchroniser and time base
  logic [NK+2:0] pin_a, pin_b;
  logic [NK-1:0] key_s;
  logic rem_s, sim_s, frc_s;
  assign {key_s, rem_s, sim_s, frc_s} = pin_b;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pin_a <= '0;
      pin_b <= '0;
    end else begin
      pin_a <= {key_in, remote_start_in, mains_sim_in, forced_start_input};
      pin_b <= pin_a;
    end
  end

  logic [31:0] ms_cnt;
  logic [9:0] ms_in_s;
  logic ms_tick, sec_tick;
  assign ms_tick = ms_cnt == 32'(MS_CYC_P - 1);
  assign sec_tick = ms_tick && ms_in_s == 10'(MS_PER_S - 1);
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ms_cnt <= 32'h0;
      ms_in_s <= 10'h000;
    end else begin
      ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
      if (sec_tick) ms_in_s <= 10'h000;
      else if (ms_tick) ms_in_s <= ms_in_s + 10'h001;
    end
  end

  // ==========================================================
  // key debounce and events
  logic [NK-1:0] key_db, key_prev, press;
  for (genvar k = 0; k < NK; k++) begin : g_deb
    logic [7:0] dcnt;
    logic db;
    assign key_db[k] = db;
    always_ff @(posedge clock) begin
      if (!rst_b) begin
        dcnt <= 8'h00;
        db <= 1'b0;
      end else if (key_s[k] == db) begin
        dcnt <= 8'h00;
      end else if (ms_tick) begin
        if (dcnt == 8'(DEB_MS - 1)) begin
          db <= key_s[k];
          dcnt <= 8'h00;
        end else begin
          dcnt <= dcnt + 8'h01;
        end
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) key_prev <= '0;
    else key_prev <= key_db;
  end
  assign press = key_db & ~key_prev;

  logic [15:0] ns_ms;
  logic lamp_check, ns_short;
  logic [31:0] combo_ms;
  logic svc_combo, prg_combo, combo_fire;
  assign lamp_check = key_db[K_NS] && !key_db[K_PS] && ns_ms >= 16'(LONG_MS);
  assign ns_short = !key_db[K_NS] && key_prev[K_NS] && ns_ms < 16'(LONG_MS) &&
                    !key_db[K_PS];
  assign svc_combo = key_db[K_NS] && key_db[K_PS];
  assign prg_combo = key_db[K_NG] && key_db[K_PG];
  assign combo_fire = ms_tick && combo_ms == 32'(HOLD_MS_P - 1);
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ns_ms <= 16'h0000;
      combo_ms <= 32'h0;
    end else begin
      if (!key_db[K_NS]) ns_ms <= key_prev[K_NS] ? ns_ms : 16'h0000;
      else if (press[K_NS]) ns_ms <= 16'h0000;
      else if (ms_tick && ns_ms < 16'(LONG_MS)) ns_ms <= ns_ms + 16'h0001;
      if (!(svc_combo || prg_combo)) combo_ms <= 32'h0;
      else if (ms_tick && combo_ms < 32'(HOLD_MS_P)) combo_ms <= combo_ms + 32'h1;
    end
  end

  // ==========================================================
  // mode, programming, service
  logic svc_clr, svc_due;
  logic [1:0] sev;
  assign svc_due = (svc_hours_over || svc_time_over) && !svc_clr;
  assign sev = ctrl[CTL_SEV +: 2];
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mode <= GFP_OFF;
    end else if (press[K_OFF]) begin
      mode <= GFP_OFF;
    end else if (press[K_TEST]) begin
      mode <= GFP_TEST;
    end else if (press[K_RUN]) begin
      mode <= GFP_RUN;
    end else if (press[K_AUTO]) begin
      mode <= GFP_AUTO;
    end else if (cmd_wr && $onehot(pwdata[3:0])) begin
      mode <= gfp_mode_t'(pwdata[3:0]);
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prog_mode <= 1'b0;
      svc_clr <= 1'b0;
      service_reset <= 1'b0;
      alarm_relay_release <= 1'b0;
    end else begin
      if (combo_fire && prg_combo) prog_mode <= 1'b1;
      else if (cmd_wr && pwdata[CMD_PEXIT]) prog_mode <= 1'b0;
      if (combo_fire && svc_combo) svc_clr <= 1'b1;
      else if (!(svc_hours_over || svc_time_over)) svc_clr <= 1'b0;
      service_reset <= combo_fire && svc_combo;
      alarm_relay_release <= press[K_PS];
    end
  end

  // ==========================================================
  // supply status and contactors
  logic mains_pres, gen_ok, gen_pres, mains_ok;
  logic man_m, man_g, next_mc, next_gc;
  always_comb begin
    mains_pres = mains_volt_ok && mains_freq_ok && (!ctrl[CTL_MROT] || mains_rot_ok);
    if (ctrl[CTL_REM]) mains_pres = rem_s;
    if (sim_s) mains_pres = 1'b1;
    if (frc_s) mains_pres = 1'b0;
  end
  assign gen_ok = gen_volt_ok && gen_freq_ok;
  assign gen_pres = gen_ok && (!ctrl[CTL_GROT] || gen_rot_ok);
  assign mains_ok = mains_volt_ok && mains_freq_ok;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      man_m <= 1'b0;
      man_g <= 1'b0;
    end else if (mode == GFP_RUN) begin
      if (press[K_MCB]) man_m <= !man_m;
      if (press[K_GCB]) man_g <= !man_g;
    end
  end
  always_comb begin
    case (mode)
      GFP_RUN: begin
        next_gc = man_g;
        next_mc = man_m;
      end
      GFP_TEST: begin
        next_gc = 1'b1;
        next_mc = 1'b0;
      end
      GFP_AUTO: begin
        next_gc = !mains_pres;
        next_mc = mains_pres;
      end
      default: begin
        next_gc = 1'b0;
        next_mc = mains_pres;
      end
    endcase
    next_gc = next_gc && gen_ok;
    next_mc = next_mc && mains_ok && !next_gc;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mains_contactor <= 1'b0;
      gen_contactor <= 1'b0;
    end else begin
      mains_contactor <= next_mc;
      gen_contactor <= next_gc;
    end
  end

  // ==========================================================
  // lamps
  logic [15:0] fl_ms;
  logic flash;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      fl_ms <= 16'h0000;
      flash <= 1'b0;
    end else if (ms_tick) begin
      if (fl_ms == 16'(FLASH_MS - 1)) begin
        fl_ms <= 16'h0000;
        flash <= !flash;
      end else begin
        fl_ms <= fl_ms + 16'h0001;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      {mode_lamp, alarm_lamp, warning_lamp, service_lamp} <= 7'h00;
      {mains_avail_lamp, mains_cb_lamp, gen_cb_lamp, gen_avail_lamp} <= 4'h0;
      service_out <= '0;
      service_fault <= 2'h0;
    end else begin
      mode_lamp <= lamp_check ? 4'hf : mode;
      alarm_lamp <= lamp_check || shutdown_fault || loaddump_fault;
      warning_lamp <= lamp_check || warning_fault;
      service_lamp <= lamp_check || (svc_due && flash);
      mains_avail_lamp <= lamp_check || mains_pres;
      mains_cb_lamp <= lamp_check || next_mc;
      gen_cb_lamp <= lamp_check || next_gc;
      gen_avail_lamp <= lamp_check || gen_pres;
      service_out <= svc_due ? route : '0;
      service_fault <= svc_due ? sev : 2'h0;
    end
  end

  // ==========================================================
  // display navigation and scroll
  logic [2:0] flt_prev;
  logic new_fault, scroll_tick, in_scroll;
  logic [7:0] susp, scr_s;
  logic [4:0] gsize;
  logic [3:0] glast;
  function automatic logic [3:0] step_grp(input logic [3:0] g, input logic fwd,
                                          input logic can);
    logic [3:0] n;
    n = fwd ? (g == G_LAST ? 4'h0 : g + 4'h1) : (g == 4'h0 ? G_LAST : g - 4'h1);
    if (n == G_EBUS && !can) n = fwd ? G_MAINS : G_ENG;
    return n;
  endfunction
  always_comb begin
    case (group)
      G_GEN: gsize = SZ_GEN;
      G_ENG: gsize = SZ_ENG;
      G_MAINS: gsize = ctrl[CTL_CT] ? SZ_MFULL : SZ_MVOLT;
      G_ALARM: gsize = {1'b0, alarm_count} + 5'h01;
      4'h8, 4'h9: gsize = SZ_COMM;
      G_LAST: gsize = SZ_STAT;
      default: gsize = SZ_WAVE;
    endcase
  end
  assign glast = 4'(gsize - 5'h01);
  assign new_fault = |({shutdown_fault, loaddump_fault, warning_fault} & ~flt_prev);
  assign in_scroll = group == G_GEN || group == G_ENG || group == G_MAINS;
  assign scroll_tick = sec_tick && susp == 8'h00 && !prog_mode && in_scroll &&
                       scroll_int != 8'h00 && scr_s >= scroll_int - 8'h01;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flt_prev <= 3'h0;
      susp <= 8'h00;
      scr_s <= 8'h00;
    end else begin
      flt_prev <= {shutdown_fault, loaddump_fault, warning_fault};
      if (|press) susp <= 8'(SUSP_S);
      else if (sec_tick && susp != 8'h00) susp <= susp - 8'h01;
      if (|press || scroll_tick) scr_s <= 8'h00;
      else if (sec_tick) scr_s <= scr_s + 8'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      group <= G_GEN;
      screen <= 4'h0;
    end else if (new_fault) begin
      group <= G_ALARM;
      screen <= 4'h0;
    end else if (press[K_NG]) begin
      group <= step_grp(group, 1'b1, ctrl[CTL_CAN]);
      screen <= 4'h0;
    end else if (press[K_PG]) begin
      group <= step_grp(group, 1'b0, ctrl[CTL_CAN]);
      screen <= 4'h0;
    end else if (ns_short) begin
      screen <= screen >= glast ? 4'h0 : screen + 4'h1;
    end else if (press[K_PS]) begin
      screen <= screen == 4'h0 || screen > glast ? glast : screen - 4'h1;
    end else if (scroll_tick) begin
      if (screen >= glast) begin
        group <= group == G_MAINS ? G_GEN : (group == G_GEN ? G_ENG : G_MAINS);
        screen <= 4'h0;
      end else begin
        screen <= screen + 4'h1;
      end
    end else if (group == G_EBUS && !ctrl[CTL_CAN]) begin
      group <= G_MAINS;
      screen <= 4'h0;
    end else if (screen > glast) begin
      screen <= glast;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_gen_drop;
    !gen_ok |=> !gen_contactor;
  endproperty
  a_gen_drop: assert property (p_gen_drop) else $error("contactor on bad genset");
  property p_cb_lamp;
    mains_contactor |-> mains_cb_lamp;
  endproperty
  a_cb_lamp: assert property (p_cb_lamp) else $error("mains lamp off");
  property p_grp_wrap;
    !new_fault && press[K_NG] && group == G_LAST |=> group == 4'h0;
  endproperty
  a_grp_wrap: assert property (p_grp_wrap) else $error("group wrap fail");
  property p_fault_page;
    new_fault |=> group == G_ALARM && screen == 4'h0;
  endproperty
  a_fault_page: assert property (p_fault_page) else $error("alarm page missed");
  property p_force;
    frc_s |=> !mains_avail_lamp || $past(lamp_check);
  endproperty
  a_force: assert property (p_force) else $error("force not absent");
  property p_man_hold;
    mode != GFP_RUN |=> $stable(man_m) && $stable(man_g);
  endproperty
  a_man_hold: assert property (p_man_hold) else $error("manual toggle out of run");
  property p_prog_entry;
    $rose(prog_mode) |-> $past(combo_ms) == 32'(HOLD_MS_P - 1) && $past(prg_combo);
  endproperty
  a_prog_entry: assert property (p_prog_entry) else $error("early programming");
  property p_lamp_check;
    lamp_check |=> alarm_lamp && warning_lamp && gen_cb_lamp && mode_lamp == 4'hf;
  endproperty
  a_lamp_check: assert property (p_lamp_check) else $error("lamp check fail");
  property p_suspend;
    |press |=> susp == 8'(SUSP_S) ##1 !scroll_tick;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend not loaded");
  property p_skip_bus;
    !ctrl[CTL_CAN] && group != G_EBUS && $stable(ctrl) |=> group != G_EBUS;
  endproperty
  a_skip_bus: assert property (p_skip_bus) else $error("bus group shown");
endmodule // gfp_panel

// File: rtl/gfp_pkg.sv
// Summary of operation
// - service expiry flashes lamp, asserts service output
// - service output routable; optional fault severity
// - mute plus lamp-check held 5 s resets service
// - mode keys select test, run, auto, off
// - run mode only: keys toggle contactors
// - programming combination held 5 s enters programming
// - next-screen short advances, held gives lamp check
// - previous-screen key also releases alarm relay
// - group keys step groups with wrap
// - screen keys step items with wrap
// - engine-bus group skipped unless port enabled
// - mains current items only with load-side transformers
// - alarm group lists alarms then terminator
// - auto scroll mains, genset, engine screens
// - any key suspends scrolling two minutes
// - new fault forces alarm list page
// - alarm, warning and service lamps follow conditions
// - mode lamps follow local or remote selection
// - mains lamp needs volts, frequency, rotation
// - remote, simulate and force inputs steer mains
// - contactor lamps follow contactor outputs
// - genset lamp needs volts, frequency, rotation
// - genset contactor dropped on bad genset supply
package gfp_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYC = CLK_HZ / MS_PER_S;
  localparam int HOLD_S = 5;
  localparam int HOLD_MS = HOLD_S * MS_PER_S;
  localparam int SUSP_MIN = 2;
  localparam int SUSP_S = SUSP_MIN * 60;
  localparam int DEB_MS = 20;
  localparam int LONG_MS = 1000;
  localparam int FLASH_MS = 500;
  // ==========================================================
  // register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SCROLL = 8'h04;
  localparam logic [7:0] OFS_ROUTE = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam int CTL_CAN = 0;
  localparam int CTL_CT = 1;
  localparam int CTL_MROT = 2;
  localparam int CTL_GROT = 3;
  localparam int CTL_REM = 4;
  localparam int CTL_SEV = 8;
  localparam int CTL_W = 10;
  localparam int CMD_PEXIT = 8;
  localparam logic [CTL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [7:0] SCROLL_RST = 8'h0e;
  // ==========================================================
  // keys
  localparam int K_TEST = 0;
  localparam int K_RUN = 1;
  localparam int K_AUTO = 2;
  localparam int K_OFF = 3;
  localparam int K_NS = 4;
  localparam int K_PS = 5;
  localparam int K_NG = 6;
  localparam int K_PG = 7;
  localparam int K_MCB = 8;
  localparam int K_GCB = 9;
  localparam int NK = 10;
  // ==========================================================
  // modes and display groups
  typedef enum logic [3:0] {
    GFP_OFF = 4'b0001, GFP_RUN = 4'b0010, GFP_AUTO = 4'b0100, GFP_TEST = 4'b1000
  } gfp_mode_t;
  localparam logic [3:0] G_GEN = 4'h0;
  localparam logic [3:0] G_ENG = 4'h1;
  localparam logic [3:0] G_EBUS = 4'h2;
  localparam logic [3:0] G_MAINS = 4'h3;
  localparam logic [3:0] G_ALARM = 4'h7;
  localparam logic [3:0] G_LAST = 4'ha;
  localparam logic [4:0] SZ_GEN = 5'h06;
  localparam logic [4:0] SZ_ENG = 5'h04;
  localparam logic [4:0] SZ_MFULL = 5'h06;
  localparam logic [4:0] SZ_MVOLT = 5'h03;
  localparam logic [4:0] SZ_WAVE = 5'h08;
  localparam logic [4:0] SZ_COMM = 5'h04;
  localparam logic [4:0] SZ_STAT = 5'h06;
endpackage

// File: test/gfp_operator.sv
`timescale 1ns/1ps
module gfp_operator (
  // clock
  input wire logic clock,
  // keys toward the panel
  output logic [gfp_pkg::NK-1:0] key_in
);
  // ==========================================================
  // operator hands
  // released contacts read low because the operator drives them to zero
  initial key_in = '0;
  task automatic hold(input logic [gfp_pkg::NK-1:0] keys, input int cyc);
    @(posedge clock);
    key_in <= keys;
    repeat (cyc) @(posedge clock);
    key_in <= '0;
  endtask
endmodule // gfp_operator

// File: test/tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module tb;
  import gfp_pkg::*;
  localparam int LIMIT = 80000;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, mask;
  logic [31:0] seed = 32'h26;
  logic [NK-1:0] key_in;
  logic remote_start_in = 1'b0, mains_sim_in = 1'b0, forced_start_input = 1'b0;
  logic mains_volt_ok = 1'b0, mains_freq_ok = 1'b0, mains_rot_ok = 1'b0;
  logic gen_volt_ok = 1'b0, gen_freq_ok = 1'b0, gen_rot_ok = 1'b0;
  logic shutdown_fault = 1'b0, loaddump_fault = 1'b0, warning_fault = 1'b0;
  logic svc_hours_over = 1'b0, svc_time_over = 1'b0, g0;
  logic [3:0] alarm_count = 4'h0, mode_lamp, group, screen;
  logic alarm_lamp, warning_lamp, service_lamp, mains_avail_lamp, mains_cb_lamp;
  logic gen_cb_lamp, gen_avail_lamp, mains_contactor, gen_contactor;
  logic service_reset, alarm_relay_release, prog_mode;
  logic [7:0] service_out;
  logic [1:0] service_fault;
  gfp_mode_t mode;
  int fails = 0, checked = 0, tmo = 0, lamp_on = 0;
  logic rel_seen = 1'b0, rst_seen = 1'b0;
  gfp_mode_t mtab[4] = '{GFP_TEST, GFP_RUN, GFP_AUTO, GFP_OFF};
  int gk[6] = '{K_NG, K_NG, K_PG, K_PG, K_PG, K_NG};
  logic [3:0] ge[6] = '{4'h1, 4'h3, 4'h1, 4'h0, 4'ha, 4'h0};
  logic [3:0] rt[4] = '{4'b0000, 4'b0101, 4'b1110, 4'b1001};

  always #5 clock = ~clock;

  gfp_operator i_op (.clock(clock), .key_in(key_in));

  gfp_panel #(.MS_CYC_P(10), .HOLD_MS_P(40), .NOUT(8)) i_gfp_panel (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_in(key_in), .remote_start_in(remote_start_in), .mains_sim_in(mains_sim_in),
    .forced_start_input(forced_start_input), .mains_volt_ok(mains_volt_ok),
    .mains_freq_ok(mains_freq_ok), .mains_rot_ok(mains_rot_ok), .gen_volt_ok(gen_volt_ok),
    .gen_freq_ok(gen_freq_ok), .gen_rot_ok(gen_rot_ok), .shutdown_fault(shutdown_fault),
    .loaddump_fault(loaddump_fault), .warning_fault(warning_fault),
    .svc_hours_over(svc_hours_over), .svc_time_over(svc_time_over),
    .alarm_count(alarm_count), .mode_lamp(mode_lamp), .alarm_lamp(alarm_lamp),
    .warning_lamp(warning_lamp), .service_lamp(service_lamp),
    .mains_avail_lamp(mains_avail_lamp), .mains_cb_lamp(mains_cb_lamp),
    .gen_cb_lamp(gen_cb_lamp), .gen_avail_lamp(gen_avail_lamp),
    .mains_contactor(mains_contactor), .gen_contactor(gen_contactor),
    .service_out(service_out), .service_fault(service_fault),
    .service_reset(service_reset), .alarm_relay_release(alarm_relay_release),
    .prog_mode(prog_mode), .mode(mode), .group(group), .screen(screen)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic tap(input int k);
    i_op.hold(10'(1 << k), 300);
    repeat (300) @(posedge clock);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // monitors and timeout
  always @(posedge clock) begin
    tmo++;
    if (alarm_relay_release === 1'b1)
      rel_seen = 1'b1;
    if (service_reset === 1'b1)
      rst_seen = 1'b1;
    if (service_lamp === 1'b1)
      lamp_on++;
    if (tmo >= LIMIT) begin
      fails++;
      conclude();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK("mode", GFP_OFF, mode)
    `CHK("mode_lamp", 4'h1, mode_lamp)
    apb(1'b0, OFS_SCROLL, 32'h0);
    `CHK("scroll", {24'h0, SCROLL_RST}, rd)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl", {22'h0, CTRL_RST}, rd)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("slverr", 1'b1, err)
    apb(1'b1, OFS_SCROLL, 32'h1);
    repeat (10500) @(posedge clock);
    `CHK("scroll_step", 4'h1, screen)
    apb(1'b1, OFS_SCROLL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h204);
    mains_volt_ok <= 1'b1;
    mains_freq_ok <= 1'b1;
    repeat (10) @(posedge clock);
    `CHK("mains_lamp_rot", 1'b0, mains_avail_lamp)
    mains_rot_ok <= 1'b1;
    repeat (10) @(posedge clock);
    `CHK("mains_lamp", 1'b1, mains_avail_lamp)
    `CHK("mains_cb_lamp", 1'b1, mains_cb_lamp)
    apb(1'b1, OFS_CTRL, 32'h214);
    for (int i = 0; i < 4; i++) begin
      {remote_start_in, mains_sim_in, forced_start_input} <= rt[i][3:1];
      repeat (10) @(posedge clock);
      `CHK("mains_steer", rt[i][0], mains_avail_lamp)
    end
    apb(1'b1, OFS_CTRL, 32'h200);
    for (int k = 0; k < 4; k++) begin
      tap(k);
      `CHK("mode", mtab[k], mode)
      `CHK("mode_lamp", 4'(mtab[k]), mode_lamp)
    end
    tap(K_MCB);
    `CHK("mains_ctr_off", 1'b1, mains_contactor)
    gen_volt_ok <= 1'b1;
    gen_freq_ok <= 1'b1;
    tap(K_RUN);
    `CHK("gen_lamp", 1'b1, gen_avail_lamp)
    g0 = gen_contactor;
    tap(K_GCB);
    `CHK("gen_ctr", ~g0, gen_contactor)
    `CHK("gen_cb_lamp", ~g0, gen_cb_lamp)
    gen_volt_ok <= 1'b0;
    repeat (10) @(posedge clock);
    `CHK("gen_ctr_drop", 1'b0, gen_contactor)
    gen_volt_ok <= 1'b1;
    tap(K_OFF);
    for (int i = 0; i < 6; i++) begin
      tap(gk[i]);
      `CHK("group", ge[i], group)
    end
    apb(1'b1, OFS_CTRL, 32'h201);
    tap(K_NG);
    tap(K_NG);
    `CHK("group_bus", G_EBUS, group)
    apb(1'b1, OFS_CTRL, 32'h203);
    tap(K_NG);
    tap(K_PS);
    `CHK("mains_full", 4'(SZ_MFULL - 1), screen)
    apb(1'b1, OFS_CTRL, 32'h201);
    repeat (2) @(posedge clock);
    `CHK("mains_volt", 4'(SZ_MVOLT - 1), screen)
    tap(K_PG);
    tap(K_PG);
    tap(K_PG);
    tap(K_PS);
    `CHK("screen_wrap", 4'(SZ_GEN - 1), screen)
    `CHK("relay_release", 1'b1, rel_seen)
    tap(K_NS);
    `CHK("screen_next", 4'h0, screen)
    fork
      i_op.hold(10'(1 << K_NS), 10600);
      begin
        repeat (10400) @(posedge clock);
        `CHK("lamp_check", 1'b1, warning_lamp)
      end
    join
    repeat (300) @(posedge clock);
    `CHK("screen_long", 4'h0, screen)
    alarm_count <= 4'(1 + xs() % 6);
    shutdown_fault <= 1'b1;
    repeat (10) @(posedge clock);
    `CHK("group_alarm", G_ALARM, group)
    `CHK("alarm_lamp", 1'b1, alarm_lamp)
    tap(K_PS);
    `CHK("terminator", alarm_count, screen)
    tap(K_NS);
    `CHK("alarm_wrap", 4'h0, screen)
    warning_fault <= 1'b1;
    repeat (10) @(posedge clock);
    `CHK("warning_lamp", 1'b1, warning_lamp)
    shutdown_fault <= 1'b0;
    warning_fault <= 1'b0;
    mask = xs();
    apb(1'b1, OFS_ROUTE, mask);
    svc_time_over <= 1'b1;
    repeat (10) @(posedge clock);
    lamp_on = 0;
    repeat (10000) @(posedge clock);
    `CHK("service_out", mask[7:0], service_out)
    `CHK("service_fault", 2'h2, service_fault)
    `CHK("flash", 1'b1, 1'(lamp_on > 2000 && lamp_on < 8000))
    i_op.hold(10'((1 << K_NS) | (1 << K_PS)), 300);
    repeat (300) @(posedge clock);
    `CHK("svc_short", 1'b0, rst_seen)
    i_op.hold(10'((1 << K_NS) | (1 << K_PS)), 600);
    repeat (300) @(posedge clock);
    `CHK("svc_reset", 1'b1, rst_seen)
    `CHK("svc_lamp", 1'b0, service_lamp)
    svc_time_over <= 1'b0;
    i_op.hold(10'((1 << K_NG) | (1 << K_PG)), 300);
    repeat (300) @(posedge clock);
    `CHK("prog_short", 1'b0, prog_mode)
    i_op.hold(10'((1 << K_NG) | (1 << K_PG)), 600);
    repeat (300) @(posedge clock);
    `CHK("prog", 1'b1, prog_mode)
    apb(1'b1, OFS_CMD, 32'h100);
    `CHK("prog_exit", 1'b0, prog_mode)
    apb(1'b1, OFS_CMD, 32'h2);
    apb(1'b1, OFS_CMD, 32'h3);
    `CHK("mode_remote", GFP_RUN, mode)
    `CHK("mode_lamp_remote", 4'h2, mode_lamp)
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("stat_mode", 4'h2, rd[15:12])
    conclude();
  end
endmodule // tb
